// ===== tb_top.sv
// Self-checking testbench for the transmitter interrupt and receiver control register bank.
`timescale 1ns/100ps
module tb_top;
	logic                     clk_sys;
	logic                     rst_n;
	tirs_pkg::tirs_host_req_t host_req;
	logic [7:0]               host_rdata;
	logic                     host_rvalid;
	logic [3:0]               line_input;
	logic                     receiver_ref_clock_in;
	logic                     alt_ref_clock_in;
	logic                     rx_buffer_xfer_req;
	logic                     slip_condition;
	logic                     tx_xfer_busy;
	logic                     tx_xfer_disable;
	logic                     source_slip_clear;
	logic                     buffer_xfer_done_clear;
	logic                     rx_core_data;
	logic                     pll_ref_clock_out;
	logic                     ua_buffer_load;
	logic                     source_slip_flag;
	logic                     buffer_xfer_done_flag;
	logic                     slip_irq;
	logic                     buffer_xfer_irq;
	int                       mismatches;
	int                       checks_done;

	tirs_top uut
	(
		.clk_sys(clk_sys), .rst_n(rst_n), .host_req(host_req), .host_rdata(host_rdata),
		.host_rvalid(host_rvalid), .line_input(line_input),
		.receiver_ref_clock_in(receiver_ref_clock_in), .alt_ref_clock_in(alt_ref_clock_in),
		.rx_buffer_xfer_req(rx_buffer_xfer_req), .slip_condition(slip_condition),
		.tx_xfer_busy(tx_xfer_busy), .tx_xfer_disable(tx_xfer_disable),
		.source_slip_clear(source_slip_clear), .buffer_xfer_done_clear(buffer_xfer_done_clear),
		.rx_core_data(rx_core_data), .pll_ref_clock_out(pll_ref_clock_out),
		.ua_buffer_load(ua_buffer_load), .source_slip_flag(source_slip_flag),
		.buffer_xfer_done_flag(buffer_xfer_done_flag), .slip_irq(slip_irq),
		.buffer_xfer_irq(buffer_xfer_irq)
	);

	// ------------------------------------------------------------
	// Clock, helpers and host access tasks
	// ------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic close_out();
		$display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic chk1(input logic seen, input logic exp, input string what);
		chk({7'h00, seen}, {7'h00, exp}, what);
	endtask

	// After the reset fall at 2 ns, inputs always change one nanosecond after a rising edge.
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// Each access ends with one idle cycle, so a strobe never drops and rises in one time step.
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		host_req = {1'b1, 1'b0, addr, data};
		step(1);
		host_req.wr = 1'b0;
		step(1);
	endtask

	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		host_req = {1'b0, 1'b1, addr, 8'h00};
		step(1);
		host_req.rd = 1'b0;
		chk1(host_rvalid, 1'b1, "read valid");
		chk(host_rdata, exp, "read data");
		step(1);
	endtask

	task automatic set_ev(input logic src, input logic v);
		if (src)
			tx_xfer_busy = v;
		else
			slip_condition = v;
	endtask

	task automatic clr(input logic src);
		if (src)
			buffer_xfer_done_clear = 1'b1;
		else
			source_slip_clear = 1'b1;
		step(1);
		buffer_xfer_done_clear = 1'b0;
		source_slip_clear = 1'b0;
		step(2);
	endtask

	// Source 0 is the slip interrupt, source 1 the buffer transfer interrupt.
	task automatic ev_run(input logic src, input tirs_pkg::tirs_trig_t m);
		wr(tirs_pkg::OFF_TX_IRQ_TRIGGER_MODE, src ? {6'h00, m} : {4'h0, m, 2'h0});
		set_ev(src, 1'b1);
		step(3);
		chk1(src ? buffer_xfer_done_flag : source_slip_flag, m != tirs_pkg::TRIG_FALL, "rise flag");
		chk1(src ? buffer_xfer_irq : slip_irq, m != tirs_pkg::TRIG_FALL, "rise irq");
		if (m != tirs_pkg::TRIG_LEVEL)
		begin
			clr(src);
			chk1(src ? buffer_xfer_done_flag : source_slip_flag, 1'b0, "cleared flag");
		end
		set_ev(src, 1'b0);
		step(3);
		chk1(src ? buffer_xfer_done_flag : source_slip_flag, m != tirs_pkg::TRIG_RISE, "fall flag");
		chk1(src ? buffer_xfer_irq : slip_irq, m == tirs_pkg::TRIG_FALL, "fall irq");
		clr(src);
		chk1(src ? buffer_xfer_irq : slip_irq, 1'b0, "irq after clear");
	endtask

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial
	begin
		mismatches = 0;
		checks_done = 0;
		rst_n = 1'b1;
		host_req = '0;
		line_input = 4'h0;
		receiver_ref_clock_in = 1'b0;
		alt_ref_clock_in = 1'b0;
		rx_buffer_xfer_req = 1'b0;
		slip_condition = 1'b0;
		tx_xfer_busy = 1'b0;
		tx_xfer_disable = 1'b0;
		source_slip_clear = 1'b0;
		buffer_xfer_done_clear = 1'b0;
		// Reset falls after time zero so that the asynchronous reset edge is always seen.
		#2;
		rst_n = 1'b0;
		step(16);
		rst_n = 1'b1;
		step(4);
		rd(8'h0B, 8'h00);
		rd(8'h0C, 8'h00);
		rd(8'h0D, 8'h00);
		rd(8'h0E, 8'h00);
		$display("test reset values done");
		wr(8'h0D, 8'hFF);
		rd(8'h0D, 8'h1B);
		wr(8'h0B, 8'hFF);
		rd(8'h0B, 8'h03);
		wr(8'h0C, 8'hFF);
		rd(8'h0C, 8'h00);
		wr(8'h0C, 8'hF6);
		rd(8'h0C, 8'h06);
		wr(8'h0E, 8'hFF);
		rd(8'h0E, 8'h00);
		$display("test register layout done");
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h0D, 8'(k));
			line_input = 4'h1 << k;
			step(2);
			chk1(rx_core_data, 1'b1, "selected line high");
			line_input = ~(4'h1 << k);
			step(2);
			chk1(rx_core_data, 1'b0, "selected line low");
		end
		wr(8'h0D, 8'h00);
		receiver_ref_clock_in = 1'b1;
		step(2);
		chk1(pll_ref_clock_out, 1'b1, "reference input");
		wr(8'h0D, 8'h08);
		step(2);
		chk1(pll_ref_clock_out, 1'b0, "alternate low");
		alt_ref_clock_in = 1'b1;
		receiver_ref_clock_in = 1'b0;
		step(2);
		chk1(pll_ref_clock_out, 1'b1, "alternate high");
		$display("test receiver routing done");
		for (int d = 0; d < 2; d++)
		begin
			wr(8'h0D, d ? 8'h10 : 8'h00);
			rx_buffer_xfer_req = 1'b1;
			step(1);
			rx_buffer_xfer_req = 1'b0;
			chk1(ua_buffer_load, d == 0, "buffer copy");
			step(1);
			chk1(ua_buffer_load, 1'b0, "buffer copy end");
		end
		$display("test buffer copy done");
		wr(8'h0C, 8'h00);
		wr(8'h0B, 8'h00);
		slip_condition = 1'b1;
		step(3);
		chk1(source_slip_flag, 1'b0, "masked slip flag");
		chk1(slip_irq, 1'b0, "masked slip irq");
		slip_condition = 1'b0;
		tx_xfer_disable = 1'b1;
		wr(8'h0B, 8'h01);
		tx_xfer_busy = 1'b1;
		step(3);
		chk1(buffer_xfer_done_flag, 1'b0, "disabled transfer flag");
		tx_xfer_busy = 1'b0;
		tx_xfer_disable = 1'b0;
		step(3);
		wr(8'h0B, 8'h03);
		for (int i = 0; i < 3; i++)
		begin
			ev_run(1'b0, tirs_pkg::tirs_trig_t'(i[1:0]));
			ev_run(1'b1, tirs_pkg::tirs_trig_t'(i[1:0]));
		end
		$display("test interrupt modes done");
		rst_n = 1'b0;
		step(2);
		rst_n = 1'b1;
		step(4);
		chk1(source_slip_flag, 1'b0, "slip flag after reset");
		rd(8'h0B, 8'h00);
		rd(8'h0C, 8'h00);
		rd(8'h0D, 8'h00);
		$display("test mid-run reset done");
		close_out();
	end

	initial
	begin
		#200000;
		mismatches++;
		close_out();
	end
endmodule

// ===== tirs_irq_trig.sv
// Trigger detector and sticky flag for one transmitter interrupt source.
`timescale 1ns/100ps
module tirs_irq_trig
(
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             event_in,
	input  tirs_pkg::tirs_trig_t  mode,
	input  wire logic             enable,
	input  wire logic             clear,
	output logic                  flag,
	output logic                  irq
);

	logic event_q;
	wire  fire;
	wire  next_flag;
	wire  next_irq;

	// ------------------------------------------------------------
	// Edge and level selection
	// ------------------------------------------------------------
	assign fire = (mode == tirs_pkg::TRIG_RISE)  ? (event_in & ~event_q) :
	              (mode == tirs_pkg::TRIG_FALL)  ? (~event_in & event_q) :
	              (mode == tirs_pkg::TRIG_LEVEL) ? event_in : 1'b0;

	// A new event in the clearing cycle keeps the flag set.
	assign next_flag = (fire & enable) | (flag & ~clear);
	assign next_irq  = (mode == tirs_pkg::TRIG_LEVEL) ? (event_in & enable) : next_flag;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			event_q <= 1'b0;
			flag    <= 1'b0;
			irq     <= 1'b0;
		end
		else
		begin
			event_q <= event_in;
			flag    <= next_flag;
			irq     <= next_irq;
		end
	end

endmodule

// ===== tirs_pkg.sv
// Package with register map, field layout, reset values and carrier types of the control bank.
package tirs_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_TX_IRQ_MASK         = 8'h0B;
	localparam logic [7:0] OFF_TX_IRQ_TRIGGER_MODE = 8'h0C;
	localparam logic [7:0] OFF_RX_CONTROL_ONE      = 8'h0D;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_BUFFER_XFER_IRQ_ENABLE = 0;
	localparam int BIT_SLIP_IRQ_ENABLE        = 1;
	localparam int LSB_BUFFER_XFER_IRQ_TRIG   = 0;
	localparam int LSB_SLIP_IRQ_TRIG          = 2;
	localparam int LSB_RECEIVER_INPUT_SELECT  = 0;
	localparam int BIT_PLL_REF_SELECT         = 3;
	localparam int BIT_RX_BUFFER_XFER_DISABLE = 4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [1:0] RST_IRQ_ENABLES    = 2'h0;
	localparam logic [1:0] RST_TRIGGER        = 2'h0;
	localparam logic [1:0] RST_INPUT_SELECT   = 2'h0;
	localparam logic       RST_PLL_REF_SELECT = 1'b0;
	localparam logic       RST_XFER_DISABLE   = 1'b0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		TRIG_RISE     = 2'h0,
		TRIG_FALL     = 2'h1,
		TRIG_LEVEL    = 2'h2,
		TRIG_RESERVED = 2'h3
	} tirs_trig_t;

	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tirs_host_req_t;

	typedef struct packed
	{
		logic       xfer_disable;
		logic       pll_ref_sel;
		logic [1:0] input_sel;
	} tirs_rx_ctrl_t;

endpackage

// ===== tirs_top.sv
// Transmitter interrupt mask and mode registers and receiver control register one.
`timescale 1ns/100ps
module tirs_top
(
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	input  tirs_pkg::tirs_host_req_t       host_req,
	output logic [7:0]                     host_rdata,
	output logic                           host_rvalid,
	input  wire logic [3:0]                line_input,
	input  wire logic                      receiver_ref_clock_in,
	input  wire logic                      alt_ref_clock_in,
	input  wire logic                      rx_buffer_xfer_req,
	input  wire logic                      slip_condition,
	input  wire logic                      tx_xfer_busy,
	input  wire logic                      tx_xfer_disable,
	input  wire logic                      source_slip_clear,
	input  wire logic                      buffer_xfer_done_clear,
	output logic                           rx_core_data,
	output logic                           pll_ref_clock_out,
	output logic                           ua_buffer_load,
	output logic                           source_slip_flag,
	output logic                           buffer_xfer_done_flag,
	output logic                           slip_irq,
	output logic                           buffer_xfer_irq
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_meta_n;
	logic rst_sync_n;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// ------------------------------------------------------------
	// Registers and host decode
	// ------------------------------------------------------------
	logic                 slip_irq_enable;
	logic                 buffer_xfer_irq_enable;
	tirs_pkg::tirs_trig_t slip_irq_trigger;
	tirs_pkg::tirs_trig_t buffer_xfer_irq_trigger;
	tirs_pkg::tirs_rx_ctrl_t rx_ctrl;

	// Returns true for a trigger code that may be stored.
	function automatic logic legal_trig(input logic [1:0] code);
		legal_trig = (code != tirs_pkg::TRIG_RESERVED);
	endfunction

	wire       sel_mask = host_req.addr == tirs_pkg::OFF_TX_IRQ_MASK;
	wire       sel_mode = host_req.addr == tirs_pkg::OFF_TX_IRQ_TRIGGER_MODE;
	wire       sel_rx   = host_req.addr == tirs_pkg::OFF_RX_CONTROL_ONE;
	wire [1:0] wr_bx    = host_req.wdata[tirs_pkg::LSB_BUFFER_XFER_IRQ_TRIG +: 2];
	wire [1:0] wr_sl    = host_req.wdata[tirs_pkg::LSB_SLIP_IRQ_TRIG +: 2];

	wire [7:0] rd_mask = {6'h00, slip_irq_enable, buffer_xfer_irq_enable};
	wire [7:0] rd_mode = {4'h0, slip_irq_trigger, buffer_xfer_irq_trigger};
	wire [7:0] rd_rx   = {3'h0, rx_ctrl.xfer_disable, rx_ctrl.pll_ref_sel, 1'b0,
	                      rx_ctrl.input_sel};
	wire [7:0] rd_mux  = sel_mask ? rd_mask : sel_mode ? rd_mode : sel_rx ? rd_rx : 8'h00;

	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			slip_irq_enable         <= tirs_pkg::RST_IRQ_ENABLES[tirs_pkg::BIT_SLIP_IRQ_ENABLE];
			buffer_xfer_irq_enable  <= tirs_pkg::RST_IRQ_ENABLES[tirs_pkg::BIT_BUFFER_XFER_IRQ_ENABLE];
			slip_irq_trigger        <= tirs_pkg::tirs_trig_t'(tirs_pkg::RST_TRIGGER);
			buffer_xfer_irq_trigger <= tirs_pkg::tirs_trig_t'(tirs_pkg::RST_TRIGGER);
			rx_ctrl.input_sel       <= tirs_pkg::RST_INPUT_SELECT;
			rx_ctrl.pll_ref_sel     <= tirs_pkg::RST_PLL_REF_SELECT;
			rx_ctrl.xfer_disable    <= tirs_pkg::RST_XFER_DISABLE;
			host_rdata              <= 8'h00;
			host_rvalid             <= 1'b0;
		end
		else
		begin
			if (host_req.wr && sel_mask)
			begin
				slip_irq_enable        <= host_req.wdata[tirs_pkg::BIT_SLIP_IRQ_ENABLE];
				buffer_xfer_irq_enable <= host_req.wdata[tirs_pkg::BIT_BUFFER_XFER_IRQ_ENABLE];
			end
			// A reserved trigger code leaves that field unchanged.
			if (host_req.wr && sel_mode && legal_trig(wr_bx))
				buffer_xfer_irq_trigger <= tirs_pkg::tirs_trig_t'(wr_bx);
			if (host_req.wr && sel_mode && legal_trig(wr_sl))
				slip_irq_trigger <= tirs_pkg::tirs_trig_t'(wr_sl);
			if (host_req.wr && sel_rx)
			begin
				rx_ctrl.input_sel    <= host_req.wdata[tirs_pkg::LSB_RECEIVER_INPUT_SELECT +: 2];
				rx_ctrl.pll_ref_sel  <= host_req.wdata[tirs_pkg::BIT_PLL_REF_SELECT];
				rx_ctrl.xfer_disable <= host_req.wdata[tirs_pkg::BIT_RX_BUFFER_XFER_DISABLE];
			end
			host_rvalid <= host_req.rd;
			host_rdata  <= host_req.rd ? rd_mux : host_rdata;
		end
	end

	// ------------------------------------------------------------
	// Receiver routing and buffer transfer gate
	// ------------------------------------------------------------
	wire line_selected = line_input[rx_ctrl.input_sel];
	wire ref_selected  = rx_ctrl.pll_ref_sel ? alt_ref_clock_in : receiver_ref_clock_in;
	wire next_ua_load  = rx_buffer_xfer_req & ~rx_ctrl.xfer_disable;

	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			rx_core_data      <= 1'b0;
			pll_ref_clock_out <= 1'b0;
			ua_buffer_load    <= 1'b0;
		end
		else
		begin
			rx_core_data      <= line_selected;
			pll_ref_clock_out <= ref_selected;
			ua_buffer_load    <= next_ua_load;
		end
	end

	// ------------------------------------------------------------
	// Interrupt sources
	// ------------------------------------------------------------
	wire xfer_irq_allowed = buffer_xfer_irq_enable & ~tx_xfer_disable;

	tirs_irq_trig u_slip
	(
		.clk_sys  (clk_sys),
		.rst_n    (rst_sync_n),
		.event_in (slip_condition),
		.mode     (slip_irq_trigger),
		.enable   (slip_irq_enable),
		.clear    (source_slip_clear),
		.flag     (source_slip_flag),
		.irq      (slip_irq)
	);

	tirs_irq_trig u_xfer
	(
		.clk_sys  (clk_sys),
		.rst_n    (rst_sync_n),
		.event_in (tx_xfer_busy),
		.mode     (buffer_xfer_irq_trigger),
		.enable   (xfer_irq_allowed),
		.clear    (buffer_xfer_done_clear),
		.flag     (buffer_xfer_done_flag),
		.irq      (buffer_xfer_irq)
	);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_slip_masked;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		!slip_irq_enable && !source_slip_flag |=> !source_slip_flag;
	endproperty
	a_slip_masked: assert property (p_slip_masked)
		else $error("Slip flag set while slip interrupt masked.");

	property p_bx_trig_legal;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		host_req.wr && sel_mode && wr_bx == 2'h3 |=> $stable(buffer_xfer_irq_trigger);
	endproperty
	a_bx_trig_legal: assert property (p_bx_trig_legal)
		else $error("Reserved buffer transfer trigger code was stored.");

	property p_slip_trig_legal;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		slip_irq_trigger != tirs_pkg::TRIG_RESERVED;
	endproperty
	a_slip_trig_legal: assert property (p_slip_trig_legal)
		else $error("Slip trigger holds the reserved code.");

	property p_mode_read;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		host_req.rd && sel_mode |=> host_rvalid && host_rdata[7:4] == 4'h0
			&& host_rdata[3:0] == {$past(slip_irq_trigger), $past(buffer_xfer_irq_trigger)};
	endproperty
	a_mode_read: assert property (p_mode_read)
		else $error("Mode register read returned wrong layout.");

	property p_line_route;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		1'b1 |=> rx_core_data == $past(line_input[rx_ctrl.input_sel]);
	endproperty
	a_line_route: assert property (p_line_route)
		else $error("Receiver core does not see the selected line input.");

	property p_ref_route;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		!rx_ctrl.pll_ref_sel |=> pll_ref_clock_out == $past(receiver_ref_clock_in);
	endproperty
	a_ref_route: assert property (p_ref_route)
		else $error("Recovery loop reference is not the reference clock input.");

	property p_rx_read;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		host_req.rd && sel_rx |=> host_rdata[7:5] == 3'h0 && !host_rdata[2]
			&& host_rdata[4] == $past(rx_ctrl.xfer_disable);
	endproperty
	a_rx_read: assert property (p_rx_read)
		else $error("Receiver control read returned wrong layout.");

	property p_ua_hold;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		rx_buffer_xfer_req |=> ua_buffer_load == !$past(rx_ctrl.xfer_disable);
	endproperty
	a_ua_hold: assert property (p_ua_hold)
		else $error("User buffer load ignores the transfer disable bit.");

	property p_slip_set;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		slip_irq_enable && slip_irq_trigger == tirs_pkg::TRIG_RISE
			&& $rose(slip_condition) |=> source_slip_flag;
	endproperty
	a_slip_set: assert property (p_slip_set)
		else $error("Slip flag missed a rising slip condition.");

	property p_xfer_gate;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		$rose(buffer_xfer_done_flag) |-> $past(buffer_xfer_irq_enable) && !$past(tx_xfer_disable);
	endproperty
	a_xfer_gate: assert property (p_xfer_gate)
		else $error("Transfer done flag set while transfers or interrupt disabled.");

	property p_level_irq;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		slip_irq_trigger == tirs_pkg::TRIG_LEVEL ##1 slip_irq_trigger == tirs_pkg::TRIG_LEVEL
			|-> slip_irq == ($past(slip_condition) && $past(slip_irq_enable));
	endproperty
	a_level_irq: assert property (p_level_irq)
		else $error("Level mode slip interrupt does not follow the condition.");

	c_level_mode: cover property (@(posedge clk_sys) disable iff (!rst_sync_n)
		slip_irq_trigger == tirs_pkg::TRIG_LEVEL && slip_irq);
	c_fall_xfer: cover property (@(posedge clk_sys) disable iff (!rst_sync_n)
		buffer_xfer_irq_trigger == tirs_pkg::TRIG_FALL && $rose(buffer_xfer_done_flag));
	c_ua_held: cover property (@(posedge clk_sys) disable iff (!rst_sync_n)
		rx_buffer_xfer_req && rx_ctrl.xfer_disable);
	c_line4: cover property (@(posedge clk_sys) disable iff (!rst_sync_n)
		rx_ctrl.input_sel == 2'h3);

endmodule
